//--- design/pactl_pkg.sv
package pactl_pkg;
  // ==========================================================================
  // Clock and timebase
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Timers, counted in 1 ms ticks
  localparam int               TMR_W   = 15;
  localparam logic [TMR_W-1:0] TMR_ONE = 15'h0001;
  localparam int TM_T1   = 0;
  localparam int TM_T2   = 1;
  localparam int TM_T3   = 2;
  localparam int TM_T4   = 3;
  localparam int TM_ACT  = 4;
  localparam int TM_LOSS = 5;
  localparam int TM_FAR  = 6;
  localparam int TM_NUM  = 7;
  localparam int LD_NUM  = 5;
  // Order: activation, settle, reply, remote start, hold
  localparam logic [LD_NUM-1:0][TMR_W-1:0] LD_MIN =
    {15'h6978, 15'h0001, 15'h0001, 15'h076C, 15'h1388};
  localparam logic [LD_NUM-1:0][TMR_W-1:0] LD_MAX =
    {15'h7918, 15'h0FA0, 15'h0F9F, 15'h0833, 15'h2710};
  localparam logic [LD_NUM-1:0][TMR_W-1:0] LD_RST =
    {15'h7148, 15'h0FA0, 15'h07D0, 15'h07D0, 15'h1D4C};
  // Just over 2 s and 1 s
  localparam logic [TMR_W-1:0] LOSS_MS = 15'h07D1;
  localparam logic [TMR_W-1:0] FAR_MS  = 15'h03E9;

  // ==========================================================================
  // Register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LD0    = 8'h08;
  localparam logic [7:0] REG_LAST   = 8'h18;
  localparam int         CTRL_QUIET  = 0;
  localparam int         CTRL_ACTIVATION_REQUEST = 1;
  localparam int         CTRL_REMOTE = 2;
  localparam int         CTRL_REPEAT = 3;

  // ==========================================================================
  // Line side
  localparam logic [7:0] MARGIN_MIN   = 8'hF6;
  localparam logic [2:0] FAR_ZERO_RUN = 3'h6;
  localparam logic [1:0] SK_PAYLOAD   = 2'h0;
  localparam logic [1:0] SK_OVH       = 2'h1;
  localparam logic [1:0] SK_SYNC      = 2'h2;
  localparam logic [1:0] SK_STUFF     = 2'h3;
  localparam int          SCR_W      = 23;
  localparam int          SCR_TAP_A  = 4;
  localparam int          SCR_TAP_B  = 22;
  localparam logic [22:0] SCR_SEED   = 23'h000001;

  typedef enum logic [3:0] {
    ST_INACTIVE    = 4'h0,
    ST_WAIT_T2     = 4'h1,
    ST_SEND_S0     = 4'h2,
    ST_HOLD        = 4'h3,
    ST_SEND_S1     = 4'h4,
    ST_REPLY       = 4'h5,
    ST_ACTIVE_RX   = 4'h6,
    ST_ACTIVE_TXRX = 4'h7,
    ST_PENDING     = 4'h8,
    ST_DEACT       = 4'h9
  } pactl_state_e;

  typedef enum logic [1:0] {
    M_SILENT = 2'h0,
    M_TWO    = 2'h1,
    M_FOUR   = 2'h2,
    M_DATA   = 2'h3
  } pactl_mode_e;
endpackage

//--- design/pactl_timer.sv
`timescale 1ns/1ps
module pactl_timer
  import pactl_pkg::*;
(
  input  wire logic             clk_in,      // System clock
  input  wire logic             rst_n_in,    // Synchronised reset
  input  wire logic             tick_in,     // Timebase tick
  input  wire logic             start_in,    // Load and run
  input  wire logic             stop_in,     // Halt and clear
  input  wire logic [TMR_W-1:0] load_in,     // Ticks to expiry
  output logic                  running_out, // Counting
  output logic                  expired_out  // Reached zero
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             run;
    logic             exp;
  } pactl_tmr_s;

  pactl_tmr_s s;
  pactl_tmr_s n;

  always_comb begin
    n = s;
    if (start_in) begin
      n.cnt = load_in;
      n.run = 1'b1;
      n.exp = 1'b0;
    end else if (stop_in) begin
      n.run = 1'b0;
      n.exp = 1'b0;
    end else if (tick_in && s.run) begin
      if (s.cnt <= TMR_ONE) begin
        n.run = 1'b0;
        n.exp = 1'b1;
      end else begin
        n.cnt = s.cnt - TMR_ONE;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign running_out = s.run;
  assign expired_out = s.exp;
endmodule

//--- design/pactl_top.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pactl_top
  import pactl_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic        clk_in,            // 50 MHz clock
  input  wire logic        rst_n_in,          // Async reset, active low
  input  wire logic        psel_in,           // APB select
  input  wire logic        penable_in,        // APB enable
  input  wire logic        pwrite_in,         // APB write
  input  wire logic [7:0]  paddr_in,          // APB byte address
  input  wire logic [31:0] pwdata_in,         // APB write data
  input  wire logic [3:0]  pstrb_in,          // APB byte strobes
  output logic             pready_out,        // APB ready
  output logic [31:0]      prdata_out,        // APB read data
  output logic             pslverr_out,       // APB error
  input  wire logic        signal_detect_in,  // Peer energy seen
  input  wire logic        frame_sync_in,     // Frame sync held
  input  wire logic [7:0]  margin_in,         // Noise margin, half dB
  input  wire logic        far_ovh_strobe_in, // Peer ready bit valid
  input  wire logic        far_ready_bit_in,  // Peer ready bit, 0 ready
  input  wire logic [1:0]  rx_quat_in,        // Received data
  input  wire logic        sym_strobe_in,     // Transmit symbol slot
  input  wire logic [1:0]  sym_kind_in,       // Slot kind
  input  wire logic        frame_start_in,    // New frame
  input  wire logic [1:0]  sync_quat_in,      // Sync or stuff quat
  input  wire logic [1:0]  ovh_quat_in,       // Overhead bits
  input  wire logic        ovh_own_in,        // Overhead is ours
  input  wire logic [1:0]  payload_quat_in,   // Payload bits
  output logic             tx_enable_out,     // Line driver on
  output logic [1:0]       tx_quat_out,       // Sign, inner level
  output logic [1:0]       core_data_out,     // Data to core
  output logic             ovh_ready_bit_out, // Our ready bit, 0 ready
  output logic             rx_ready_out,      // Receiver ready
  output logic             sync_word_missing_out,  // No frame sync
  output logic             sync_loss_timeout_out,  // Sync lost too long
  output logic             line_signal_absent_out, // No peer signal
  output logic             far_signal_absent_out   // No peer signal 1 s
);
  localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

  typedef struct packed {
    logic [15:0]                   tick_cnt;
    logic                          tick;
    pactl_state_e                  st;
    logic                          quiet;
    logic                          act_req;
    logic                          remote;
    logic                          repeater;
    logic [LD_NUM-1:0][TMR_W-1:0]  ld;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
    logic                          sync_word_missing;
    logic                          sync_loss_timeout;
    logic                          line_signal_absent;
    logic                          lost;
    logic                          rx_ready;
    logic                          tact_exp;
    logic                          far_ok;
    logic [2:0]                    zero_run;
    logic [SCR_W-1:0]              scr;
    logic                          stuff_sign;
    logic                          tx_en;
    logic [1:0]                    quat;
    logic [1:0]                    core_data;
    logic                          ovh_ready_bit;
  } pactl_top_s;

  // ==========================================================================
  // Helpers
  function automatic pactl_mode_e mode_of(input pactl_state_e st);
    unique case (st)
      ST_SEND_S0, ST_HOLD, ST_REPLY: return M_TWO;
      ST_SEND_S1, ST_ACTIVE_RX:      return M_FOUR;
      ST_ACTIVE_TXRX, ST_PENDING:    return M_DATA;
      default:                       return M_SILENT;
    endcase
  endfunction

  function automatic logic rx_active(input pactl_state_e st);
    return (st == ST_ACTIVE_RX) || (st == ST_ACTIVE_TXRX) ||
           (st == ST_PENDING);
  endfunction

  // Returns scrambled bit above the new state
  function automatic logic [SCR_W:0] scr_step(input logic [SCR_W-1:0] sr,
                                              input logic d);
    logic b;
    b = d ^ sr[SCR_TAP_A] ^ sr[SCR_TAP_B];
    return {b, sr[SCR_W-2:0], b};
  endfunction

  function automatic logic [TMR_W-1:0] clamp_ld(input logic [TMR_W-1:0] v,
                                                input logic [TMR_W-1:0] lo,
                                                input logic [TMR_W-1:0] hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // Valid bit above word index
  function automatic logic [3:0] reg_decode(input logic [7:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a <= REG_LAST);
    return {ok, a[4:2]};
  endfunction

  // ==========================================================================
  // Reset release
  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ==========================================================================
  // Timers
  pactl_top_s                   s;
  pactl_top_s                   n;
  logic [TM_NUM-1:0]            start_v;
  logic [TM_NUM-1:0]            stop_v;
  logic [TM_NUM-1:0]            tmr_exp;
  logic [TM_NUM-1:0][TMR_W-1:0] tmr_load;

  assign tmr_load = {FAR_MS, LOSS_MS, s.ld};

  for (genvar g = 0; g < TM_NUM; g++) begin : g_tmr
    pactl_timer u_tmr (
      .clk_in      (clk_in),
      .rst_n_in    (rst_n),
      .tick_in     (s.tick),
      .start_in    (start_v[g]),
      .stop_in     (stop_v[g]),
      .load_in     (tmr_load[g]),
      .running_out (),
      .expired_out (tmr_exp[g])
    );
  end

  // ==========================================================================
  // Next state
  logic [3:0]       dec;
  logic [2:0]       li;
  logic [TMR_W-1:0] wv;
  logic [31:0]      stat;
  logic [31:0]      rd;
  logic [1:0]       d;
  logic [SCR_W:0]   r1;
  logic [SCR_W:0]   r2;
  pactl_mode_e      mode;

  always_comb begin
    n = s;
    start_v = '0;
    stop_v = '0;
    dec = reg_decode(paddr_in);
    li = dec[2:0] - 3'h2;
    wv = '0;
    d = 2'h3;
    r1 = '0;
    r2 = '0;
    mode = mode_of(s.st);
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.tick = 1'b0;
    if (s.tick_cnt == TICK_LAST) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = s.tick_cnt + 16'h0001;
    end
    // Register bus: answer one cycle into the access phase
    stat = {18'h0, tmr_exp[TM_T4], s.far_ok, s.tact_exp, s.rx_ready,
            s.lost, s.line_signal_absent, s.sync_loss_timeout, s.sync_word_missing, mode, s.st};
    unique case (dec[2:0])
      3'h0:    rd = {28'h0, s.repeater, s.remote, s.act_req, s.quiet};
      3'h1:    rd = stat;
      3'h7:    rd = '0;
      default: rd = {17'h0, s.ld[li]};
    endcase
    if (psel_in && penable_in && !s.pready) begin
      n.pready = 1'b1;
      n.pslverr = !dec[3];
      n.prdata = (dec[3] && !pwrite_in) ? rd : 32'h0;
    end
    if (psel_in && penable_in && s.pready && pwrite_in && dec[3]) begin
      if (paddr_in == REG_CTRL && pstrb_in[0]) begin
        n.quiet = pwdata_in[CTRL_QUIET];
        n.act_req = pwdata_in[CTRL_ACTIVATION_REQUEST];
        n.remote = pwdata_in[CTRL_REMOTE];
        n.repeater = pwdata_in[CTRL_REPEAT];
      end else if (paddr_in >= REG_LD0) begin
        wv = s.ld[li];
        if (pstrb_in[0]) begin
          wv[7:0] = pwdata_in[7:0];
        end
        if (pstrb_in[1]) begin
          wv[14:8] = pwdata_in[14:8];
        end
        n.ld[li] = clamp_ld(wv, LD_MIN[li], LD_MAX[li]);
      end
    end
    // Status from the line
    n.sync_word_missing = !frame_sync_in;
    n.line_signal_absent = !signal_detect_in;
    start_v[TM_FAR] = signal_detect_in;
    n.lost = tmr_exp[TM_FAR] && !signal_detect_in;
    n.rx_ready = frame_sync_in &&
                 (($signed(margin_in) > $signed(MARGIN_MIN)) ||
                  s.tact_exp);
    n.ovh_ready_bit = !s.rx_ready;
    if (tmr_exp[TM_ACT]) begin
      n.tact_exp = 1'b1;
    end
    if (far_ovh_strobe_in) begin
      if (far_ready_bit_in) begin
        n.zero_run = 3'h0;
      end else if (s.zero_run != FAR_ZERO_RUN) begin
        n.zero_run = s.zero_run + 3'h1;
      end
    end
    n.far_ok = (s.zero_run == FAR_ZERO_RUN);
    // Activation sequence
    unique case (s.st)
      ST_INACTIVE: begin
        if (!s.quiet && !s.remote && s.act_req) begin
          n.st = ST_SEND_S0;
          start_v[TM_ACT] = 1'b1;
          n.tact_exp = 1'b0;
          n.sync_loss_timeout = 1'b0;
        end else if (!s.quiet && s.remote && signal_detect_in) begin
          n.st = ST_WAIT_T2;
          start_v[TM_T2] = 1'b1;
          n.sync_loss_timeout = 1'b0;
        end
      end
      ST_WAIT_T2: begin
        if (tmr_exp[TM_T2]) begin
          n.st = ST_SEND_S0;
          start_v[TM_ACT] = 1'b1;
          start_v[TM_T4] = 1'b1;
          n.tact_exp = 1'b0;
        end
      end
      ST_SEND_S0: begin
        if (tmr_exp[TM_ACT]) begin
          n.st = ST_DEACT;
        end else if (!s.remote && signal_detect_in) begin
          n.st = ST_HOLD;
          start_v[TM_T1] = 1'b1;
          start_v[TM_ACT] = 1'b1;
        end else if (s.remote && frame_sync_in) begin
          n.st = ST_REPLY;
          start_v[TM_T3] = 1'b1;
        end
      end
      ST_HOLD: begin
        if (tmr_exp[TM_T1]) begin
          n.st = ST_SEND_S1;
        end
      end
      ST_SEND_S1: begin
        if (frame_sync_in) begin
          n.st = ST_ACTIVE_RX;
        end else if (tmr_exp[TM_ACT]) begin
          n.st = ST_DEACT;
        end
      end
      ST_REPLY: begin
        if (tmr_exp[TM_T3]) begin
          n.st = ST_ACTIVE_RX;
        end
      end
      ST_ACTIVE_RX: begin
        if (s.far_ok || s.tact_exp) begin
          n.st = ST_ACTIVE_TXRX;
        end
      end
      ST_ACTIVE_TXRX: begin
        if (s.sync_word_missing) begin
          n.st = ST_PENDING;
          start_v[TM_LOSS] = 1'b1;
        end
      end
      ST_PENDING: begin
        if (!s.sync_word_missing) begin
          n.st = ST_ACTIVE_TXRX;
          stop_v[TM_LOSS] = 1'b1;
        end else if (tmr_exp[TM_LOSS]) begin
          n.sync_loss_timeout = 1'b1;
          n.st = ST_DEACT;
        end
      end
      ST_DEACT: begin
        if (s.remote ? s.line_signal_absent : s.lost) begin
          n.st = ST_INACTIVE;
        end
      end
      default: n.st = ST_INACTIVE;
    endcase
    if (s.quiet && s.st != ST_INACTIVE && s.st != ST_DEACT) begin
      n.st = ST_DEACT;
      start_v[TM_FAR-1:0] = '0;
      stop_v[TM_FAR-1:0] = '1;
    end
    // Transmit symbol
    n.tx_en = (mode != M_SILENT);
    if (frame_start_in && mode == M_TWO) begin
      n.stuff_sign = !s.stuff_sign;
    end
    if (sym_strobe_in && mode != M_SILENT) begin
      if (sym_kind_in == SK_SYNC || sym_kind_in == SK_STUFF) begin
        if (mode == M_TWO) begin
          n.quat = {(sym_kind_in == SK_SYNC) ? sync_quat_in[1]
                                              : s.stuff_sign, 1'b0};
        end else begin
          n.quat = sync_quat_in;
        end
      end else begin
        if (mode == M_DATA) begin
          d = (sym_kind_in == SK_OVH) ? ovh_quat_in : payload_quat_in;
        end else if (mode == M_FOUR && sym_kind_in == SK_OVH) begin
          d = (s.repeater && !ovh_own_in) ? 2'h3 : ovh_quat_in;
        end
        r1 = scr_step(s.scr, d[1]);
        r2 = scr_step(r1[SCR_W-1:0], d[0]);
        n.scr = r2[SCR_W-1:0];
        n.quat = (mode == M_TWO) ? {r1[SCR_W], 1'b0}
                                 : {r1[SCR_W], r2[SCR_W]};
      end
    end
    n.core_data = rx_active(s.st) ? rx_quat_in : 2'h3;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= ST_INACTIVE;
      s.act_req <= 1'b1;
      s.ld <= LD_RST;
      s.sync_word_missing <= 1'b1;
      s.line_signal_absent <= 1'b1;
      s.scr <= SCR_SEED;
      s.quat <= 2'h0;
      s.core_data <= 2'h3;
      s.ovh_ready_bit <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign pready_out = s.pready;
  assign prdata_out = s.prdata;
  assign pslverr_out = s.pslverr;
  assign tx_enable_out = s.tx_en;
  assign tx_quat_out = s.quat;
  assign core_data_out = s.core_data;
  assign ovh_ready_bit_out = s.ovh_ready_bit;
  assign rx_ready_out = s.rx_ready;
  assign sync_word_missing_out = s.sync_word_missing;
  assign sync_loss_timeout_out = s.sync_loss_timeout;
  assign line_signal_absent_out = s.line_signal_absent;
  assign far_signal_absent_out = s.lost;

  // ==========================================================================
  // Checks
  a_quiet_deact: assert property (@(posedge clk_in) disable iff (!rst_n)
    s.quiet && s.st != ST_INACTIVE && s.st != ST_DEACT |=>
    s.st == ST_DEACT ##1 !s.tx_en)
    else $error("deactivate did not silence the unit");
  a_quiet_idle: assert property (@(posedge clk_in) disable iff (!rst_n)
    s.quiet && s.st == ST_INACTIVE |=> s.st == ST_INACTIVE && !s.tx_en)
    else $error("deactivate changed the inactive unit");
  a_activation_request_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
    s.st == ST_INACTIVE && !s.remote && !s.act_req |=> s.st != ST_SEND_S0)
    else $error("central unit started without request");
  a_sync_word_missing_track: assert property (@(posedge clk_in) disable iff (!rst_n)
    frame_sync_in [*2] |=> !s.sync_word_missing && !s.rx_ready ==
    ($signed($past(margin_in)) <= $signed(MARGIN_MIN) &&
     !$past(s.tact_exp)))
    else $error("sync flag or ready wrong under sync");
  a_ready_sync: assert property (@(posedge clk_in) disable iff (!rst_n)
    s.rx_ready |-> $past(frame_sync_in) && !s.sync_word_missing)
    else $error("ready without frame sync");
  a_silent_line: assert property (@(posedge clk_in) disable iff (!rst_n)
    mode_of(s.st) == M_SILENT |=> !s.tx_en)
    else $error("line driven in silent condition");
  a_two_levels: assert property (@(posedge clk_in) disable iff (!rst_n)
    sym_strobe_in && mode_of(s.st) == M_TWO |=> !s.quat[0])
    else $error("inner level in two-level training");
  a_stuff_swap: assert property (@(posedge clk_in) disable iff (!rst_n)
    frame_start_in && mode_of(s.st) == M_TWO |=> $changed(s.stuff_sign))
    else $error("stuff polarity not changed");
  a_core_ones: assert property (@(posedge clk_in) disable iff (!rst_n)
    !rx_active(s.st) |=> s.core_data == 2'h3)
    else $error("core data not forced to ones");
  a_sync_loss_timeout_cause: assert property (@(posedge clk_in) disable iff (!rst_n)
    $rose(s.sync_loss_timeout) |-> $past(s.st) == ST_PENDING && s.st == ST_DEACT)
    else $error("timeout flag outside pending state");
endmodule

//--- testbench/pactl_peer.sv
`timescale 1ns/1ps
// ===========================================
// Far transceiver and framer stand-in
module pactl_peer (
  input  wire logic       clk_in,     // System clock
  input  wire logic       energy_in,  // Far end transmitting
  input  wire logic       sync_in,    // Frame lock wanted
  output logic            detect_out, // Energy seen
  output logic            sync_out,   // Frame sync
  output logic            stb_out,    // Symbol slot
  output logic [1:0]      kind_out,   // Slot kind
  output logic            frame_out,  // Frame start
  output logic            ovh_out,    // Ready bit valid
  output logic            rdy_out,    // Ready bit, 0 ready
  output logic [1:0]      quat_out    // Received quat
);
  logic [7:0] cnt_r = 8'h00;
  always_ff @(posedge clk_in) cnt_r <= cnt_r + 8'h01;
  assign detect_out = energy_in;
  assign sync_out   = energy_in & sync_in;
  assign stb_out    = cnt_r[1:0] == 2'h0;
  assign frame_out  = cnt_r == 8'h00;
  assign kind_out   = cnt_r[7:3] == 5'h00 ? 2'h2 : 2'h0;
  assign ovh_out    = frame_out;
  assign rdy_out    = ~sync_out;
  // Changes every second cycle, never a stale value
  assign quat_out   = cnt_r[2:1];
endmodule

//--- testbench/pactl_top_bench.sv
`timescale 1ns/1ps
module pactl_top_bench;
  logic        clk_in, rst_n_in, psel, pen, pwr, pready, pslverr, err;
  logic        en, sy, det, fsync, stb, frm, ovs, fb, ten, ovr, rrdy;
  logic        swm, slt, lsa, fsa;
  logic [3:0]  strb;
  logic [7:0]  paddr, mg;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  kind, rxq, txq, core;
  int          failures = 0, n_compared = 0, cyc = 0, n;
  pactl_top #(.TICK_DIV(4)) u_pactl_top (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(strb), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .signal_detect_in(det),
    .frame_sync_in(fsync), .margin_in(mg), .far_ovh_strobe_in(ovs),
    .far_ready_bit_in(fb), .rx_quat_in(rxq), .sym_strobe_in(stb),
    .sym_kind_in(kind), .frame_start_in(frm), .sync_quat_in(2'h2),
    .ovh_quat_in(2'h3), .ovh_own_in(1'b1), .payload_quat_in(2'h1),
    .tx_enable_out(ten), .tx_quat_out(txq), .core_data_out(core),
    .ovh_ready_bit_out(ovr), .rx_ready_out(rrdy),
    .sync_word_missing_out(swm), .sync_loss_timeout_out(slt),
    .line_signal_absent_out(lsa), .far_signal_absent_out(fsa));
  pactl_peer u_pactl_peer (.clk_in(clk_in), .energy_in(en),
    .sync_in(sy), .detect_out(det), .sync_out(fsync), .stb_out(stb),
    .kind_out(kind), .frame_out(frm), .ovh_out(ovs), .rdy_out(fb),
    .quat_out(rxq));
  // ===========================================
  // Shared tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ===========================================
  // Scenarios
  task t_reset;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h2);
    apb(1'b0, 8'h04, 32'h0);
    chk("state", rd[3:0], 32'h2);
    chk("flags", {swm, lsa, core}, 32'hF);
    apb(1'b0, 8'h08, 32'h0);
    chk("hold", rd, 32'h1D4C);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", err, 32'h1);
    @(negedge clk_in iff stb);
    @(negedge clk_in);
    chk("level", {ten, txq[0]}, 32'h2);
    $display("reset test done");
  endtask
  task t_quiet;
    apb(1'b1, 8'h00, 32'h5);
    repeat (4) @(negedge clk_in);
    chk("silent", ten, 32'h0);
    @(posedge clk_in);
    en <= 1'b1;
    repeat (20) @(negedge clk_in);
    apb(1'b0, 8'h04, 32'h0);
    chk("idle", {rd[8], rd[3:0], ten}, 32'h0);
    $display("quiet test done");
  endtask
  task t_remote;
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("clamp", rd, 32'h76C);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h4);
    n = 0;
    while (ten !== 1'b1) begin
      @(negedge clk_in);
      n++;
    end
    chk("delay", n >= 7600 && n < 8400, 32'h1);
    @(posedge clk_in);
    sy <= 1'b1;
    repeat (4) @(negedge clk_in);
    chk("locked", {swm, rrdy, ovr}, 32'h2);
    @(posedge clk_in);
    mg <= 8'hF6;
    repeat (3) @(negedge clk_in);
    chk("margin", {rrdy, ovr}, 32'h1);
    @(posedge clk_in);
    mg <= 8'h00;
    rd = 32'h0;
    while (rd[3:0] !== 4'h7) apb(1'b0, 8'h04, 32'h0);
    $display("remote test done");
  endtask
  task t_loss;
    @(posedge clk_in);
    sy <= 1'b0;
    n = 0;
    while (slt !== 1'b1) begin
      @(negedge clk_in);
      n++;
    end
    chk("lost", n > 8000 && n < 8100, 32'h1);
    repeat (2) @(negedge clk_in);
    chk("deact", {swm, rrdy, ten}, 32'h4);
    $display("loss test done");
  endtask
  task t_far;
    @(posedge clk_in);
    en <= 1'b0;
    n = 0;
    while (fsa !== 1'b1) begin
      @(negedge clk_in);
      n++;
    end
    chk("far", n > 4000 && n < 4100, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("gone", {rd[9:8], rd[3:0]}, 32'h30);
    $display("far test done");
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      results;
    end
  end
  initial begin
    {psel, pen, pwr, en, sy, rst_n_in} = 6'h00;
    paddr = 8'h00;
    mg = 8'h00;
    pwdata = 32'h0;
    strb = 4'hF;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset;
    t_quiet;
    t_remote;
    t_loss;
    t_far;
    results;
  end
endmodule
